/* common/asr_pkg.sv */
// Shared constants and types for the sample and status register group.
package asr_pkg;

  // ****************************************************************
  // Register map.
  // ****************************************************************
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_X_HI = 8'h01;
  localparam logic [7:0] ADDR_X_LO = 8'h02;
  localparam logic [7:0] ADDR_Y_HI = 8'h03;
  localparam logic [7:0] ADDR_Y_LO = 8'h04;
  localparam logic [7:0] ADDR_Z_HI = 8'h05;
  localparam logic [7:0] ADDR_Z_LO = 8'h06;
  localparam logic [7:0] ADDR_OPSTATE = 8'h0b;
  localparam logic [7:0] ADDR_AFTER_OPSTATE = 8'h0c;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;

  // ****************************************************************
  // Field layout.
  // ****************************************************************
  localparam int BIT_ALL_OW = 7;
  localparam int OW_LSB = 4;
  localparam int BIT_ALL_DR = 3;
  localparam int DR_LSB = 0;
  localparam int SAMPLE_W = 10;
  localparam int AXES = 3;
  localparam int LO_PAD = 6;

  // ****************************************************************
  // Operating states, serial port settings and sample buffer size.
  // ****************************************************************
  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_WAKE = 2'h1;
  localparam logic [1:0] MODE_SLEEP = 2'h2;
  localparam logic [1:0] OPSTATE_RST = MODE_STANDBY;
  // Serial slave address; the value is arbitrary.
  localparam logic [6:0] DEV_ADDR = 7'h2b;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = AXES * SAMPLE_W;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_REG = 4'h3,
    ST_REG_ACK = 4'h4,
    ST_WDATA = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA = 4'h7,
    ST_RDATA_ACK = 4'h8
  } asr_state_t;

endpackage

/* rtl/asr_sample_regs.sv */
// Sample buffer and serial-read register group with ready and overwrite flags.
//
// Contract
// RULE1: Combined overwrite flag sets when a new sample set overwrites unread data.
// RULE2: Combined overwrite flag clears once every active axis high byte is read.
// RULE3: Per-axis overwrite flag sets on unread replacement, clears on high-byte read.
// RULE4: Combined ready flag sets on new enabled sample, clears after enabled high bytes read.
// RULE5: Per-axis ready flag sets on new sample, clears on its high-byte read.
// RULE6: Each axis sample is ten-bit two's complement across high and low bytes.
// RULE7: High byte holds bits nine to two; low byte bits one, zero on top.
// RULE8: Six sample bytes follow status at consecutive addresses; seven-byte burst.
// RULE9: Fast-read makes auto-increment skip low bytes; four-byte burst.
// RULE10: Host reads a low byte only right after its high byte.
// RULE11: High and low bytes read in sequence come from one sample.
// RULE12: Two-bit operating state: 00 standby, 01 wake, 10 sleep; upper bits zero.
// RULE13: Leaving standby for active clears status, samples and operating state.
// RULE14: Auto-increment only in burst reads; stop discards the stored address.
// RULE15: Writes to these read-only registers are ignored and change nothing.

// ******************************************************************
// Sample FIFO.
// ******************************************************************
module asr_fifo #(
  parameter int WIDTH = 30,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wrIdx_q;
  logic [AW-1:0] rdIdx_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign inReady = count_q != FULL_CNT;
  assign outValid = count_q != '0;
  assign outData = mem_q[rdIdx_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // Storage is written only at the write index.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wrIdx_q] <= inData;
    end
  end

  // Pointers wrap at the depth so it need not be a power of two.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrIdx_q <= '0;
      rdIdx_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrIdx_q <= (wrIdx_q == LAST_IDX) ? '0 : wrIdx_q + 1'b1;
      end
      if (pop) begin
        rdIdx_q <= (rdIdx_q == LAST_IDX) ? '0 : rdIdx_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

// ******************************************************************
// Register group with serial slave port.
// ******************************************************************
module asr_sample_regs (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [asr_pkg::SAMPLE_W-1:0] sampleX,
  input wire logic [asr_pkg::SAMPLE_W-1:0] sampleY,
  input wire logic [asr_pkg::SAMPLE_W-1:0] sampleZ,
  input wire logic sampleValid,
  output logic sampleReady,
  input wire logic [asr_pkg::AXES-1:0] axisEnable,
  input wire logic fastRead,
  input wire logic [1:0] modeIn
);
  import asr_pkg::*;

  // High-byte address of an axis.
  function automatic logic [7:0] hiAddr(input int axis);
    hiAddr = 8'(2 * axis + 1);
  endfunction

  // Burst auto-increment order; fast-read skips the low bytes.
  function automatic logic [7:0] nextAddr(input logic [7:0] addr, input logic fast);
    case (addr)
      // RULE8 seven-byte burst
      ADDR_STATUS: nextAddr = ADDR_X_HI;
      // RULE9 skip low bytes
      ADDR_X_HI: nextAddr = fast ? ADDR_Y_HI : ADDR_X_LO;
      ADDR_Y_HI: nextAddr = fast ? ADDR_Z_HI : ADDR_Y_LO;
      ADDR_Z_HI: nextAddr = fast ? ADDR_STATUS : ADDR_Z_LO;
      ADDR_X_LO: nextAddr = fast ? ADDR_STATUS : ADDR_Y_HI;
      ADDR_Y_LO: nextAddr = fast ? ADDR_STATUS : ADDR_Z_HI;
      ADDR_Z_LO: nextAddr = ADDR_STATUS;
      ADDR_OPSTATE: nextAddr = ADDR_AFTER_OPSTATE;
      default: nextAddr = addr + 8'h01;
    endcase
  endfunction

  // ****************************************************************
  // Reset release and pin synchronisers.
  // ****************************************************************
  logic [1:0] rstSync_q;
  logic rstN;
  logic [1:0] sclSync_q;
  logic [1:0] sdaSync_q;
  logic sclPrev_q;
  logic sdaPrev_q;
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;

  // Reset asserts at once but releases only after two clean edges.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstN = rstSync_q[1];

  // The bus pins are asynchronous to clk, so both pass two flops.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      sclSync_q <= 2'h3;
      sdaSync_q <= 2'h3;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclSync_q <= {sclSync_q[0], sclIn};
      sdaSync_q <= {sdaSync_q[0], sdaIn};
      sclPrev_q <= sclSync_q[1];
      sdaPrev_q <= sdaSync_q[1];
    end
  end

  // Bus events are seen only on the second synchroniser stage.
  assign sclRise = sclSync_q[1] && !sclPrev_q;
  assign sclFall = !sclSync_q[1] && sclPrev_q;
  assign startDet = sclSync_q[1] && sclPrev_q && sdaPrev_q && !sdaSync_q[1];
  assign stopDet = sclSync_q[1] && sclPrev_q && !sdaPrev_q && sdaSync_q[1];

  // ****************************************************************
  // Serial slave state machine.
  // ****************************************************************
  asr_state_t state_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [7:0] regPtr_q;
  logic rw_q;
  logic nack_q;
  logic sdaOe_q;
  logic loadByte;
  logic [7:0] rdData;
  logic busy;

  // A byte is fetched after the address ack, or after a master ack.
  assign loadByte = sclFall && !startDet && !stopDet &&
                    ((state_q == ST_ADDR_ACK && rw_q) ||
                     (state_q == ST_RDATA_ACK && !nack_q));
  assign busy = state_q != ST_IDLE;
  // Open-drain: the pin is only ever pulled low.
  assign sdaOut = 1'b0;
  assign sdaOe = sdaOe_q;

  // Start and stop override every state, including mid-byte.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_q <= ST_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      regPtr_q <= PTR_RST;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      sdaOe_q <= 1'b0;
    end else if (stopDet) begin
      state_q <= ST_IDLE;
      sdaOe_q <= 1'b0;
      // RULE14 stop discards address
      regPtr_q <= PTR_RST;
    end else if (startDet) begin
      state_q <= ST_ADDR;
      bitCnt_q <= 4'h0;
      sdaOe_q <= 1'b0;
    end else if (loadByte) begin
      // RULE14 burst auto-increment
      state_q <= ST_RDATA;
      tx_q <= rdData;
      sdaOe_q <= ~rdData[7];
      bitCnt_q <= 4'h0;
      regPtr_q <= nextAddr(regPtr_q, fastRead);
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          sdaOe_q <= 1'b0;
        end
        ST_ADDR, ST_REG, ST_WDATA: begin
          if (sclRise) begin
            shift_q <= {shift_q[6:0], sdaSync_q[1]};
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (sclFall && bitCnt_q == BITS_PER_BYTE) begin
            bitCnt_q <= 4'h0;
            if (state_q == ST_ADDR) begin
              rw_q <= shift_q[0];
              sdaOe_q <= shift_q[7:1] == DEV_ADDR;
              state_q <= (shift_q[7:1] == DEV_ADDR) ? ST_ADDR_ACK : ST_IDLE;
            end else if (state_q == ST_REG) begin
              regPtr_q <= shift_q;
              sdaOe_q <= 1'b1;
              state_q <= ST_REG_ACK;
            end else begin
              // RULE15 write data dropped
              sdaOe_q <= 1'b1;
              state_q <= ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (sclFall) begin
            sdaOe_q <= 1'b0;
            state_q <= ST_REG;
          end
        end
        ST_REG_ACK, ST_WDATA_ACK: begin
          if (sclFall) begin
            sdaOe_q <= 1'b0;
            state_q <= ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (sclFall) begin
            if (bitCnt_q == LAST_TX_BIT) begin
              sdaOe_q <= 1'b0;
              state_q <= ST_RDATA_ACK;
            end else begin
              tx_q <= {tx_q[6:0], 1'b0};
              sdaOe_q <= ~tx_q[6];
              bitCnt_q <= bitCnt_q + 4'h1;
            end
          end
        end
        ST_RDATA_ACK: begin
          if (sclRise) begin
            nack_q <= sdaSync_q[1];
          end else if (sclFall) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          sdaOe_q <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Sample buffer.
  // ****************************************************************
  logic [FIFO_W-1:0] fifoData;
  logic fifoValid;
  logic popSample;

  // Samples wait while a transfer is open, so one burst sees one set.
  assign popSample = fifoValid && !busy;

  asr_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) sampleFifo (
    .clk(clk),
    .rstN(rstN),
    .inData({sampleZ, sampleY, sampleX}),
    .inValid(sampleValid),
    .inReady(sampleReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(popSample)
  );

  // ****************************************************************
  // Samples, flags and operating state.
  // ****************************************************************
  logic [SAMPLE_W-1:0] sample_q [AXES];
  logic [1:0] loShadow_q [AXES];
  logic [AXES-1:0] ready_q;
  logic [AXES-1:0] overwrite_q;
  logic allReady_q;
  logic allOverwrite_q;
  logic [1:0] opState_q;
  logic [1:0] modePrev_q;
  logic [AXES-1:0] hiRead;
  logic [AXES-1:0] setReady;
  logic [AXES-1:0] setOverwrite;
  logic [AXES-1:0] readyNext;
  logic allRead;
  logic activate;

  // Leaving standby for wake or sleep counts as entering active operation.
  assign activate = modePrev_q == MODE_STANDBY && modeIn != MODE_STANDBY;

  // Per-axis read strobes and sample events.
  always_comb begin
    for (int i = 0; i < AXES; i++) begin
      hiRead[i] = loadByte && regPtr_q == hiAddr(i);
      setReady[i] = popSample && axisEnable[i];
      setOverwrite[i] = setReady[i] && ready_q[i];
    end
  end

  // RULE5 set wins over clear
  assign readyNext = (ready_q & ~hiRead) | setReady;
  // RULE2 all active high bytes read
  assign allRead = |hiRead && ((readyNext & axisEnable) == '0);

  // Sample words load only from the buffer or clear on activation; bus writes never reach them.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      for (int i = 0; i < AXES; i++) begin
        sample_q[i] <= '0;
        loShadow_q[i] <= 2'h0;
      end
    end else begin
      for (int i = 0; i < AXES; i++) begin
        if (activate) begin
          // RULE13 clear on activation
          sample_q[i] <= '0;
          loShadow_q[i] <= 2'h0;
        end else begin
          if (setReady[i]) begin
            // RULE6 ten-bit sample store
            sample_q[i] <= fifoData[i*SAMPLE_W +: SAMPLE_W];
          end
          if (hiRead[i]) begin
            // RULE11 low bits frozen at high read
            loShadow_q[i] <= sample_q[i][1:0];
          end
        end
      end
    end
  end

  // Flags: a new sample in the cycle of a read keeps its flag set.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ready_q <= '0;
      overwrite_q <= '0;
      allReady_q <= 1'b0;
      allOverwrite_q <= 1'b0;
    end else if (activate) begin
      ready_q <= '0;
      overwrite_q <= '0;
      allReady_q <= 1'b0;
      allOverwrite_q <= 1'b0;
    end else begin
      ready_q <= readyNext;
      // RULE3 per-axis overwrite
      overwrite_q <= (overwrite_q & ~hiRead) | setOverwrite;
      // RULE4 combined ready
      if (|setReady) begin
        allReady_q <= 1'b1;
      end else if (allRead) begin
        allReady_q <= 1'b0;
      end
      // RULE1 combined overwrite
      if (|setOverwrite) begin
        allOverwrite_q <= 1'b1;
      end else if (allRead) begin
        allOverwrite_q <= 1'b0;
      end
    end
  end

  // The mode is mirrored one cycle late; activation clears the copy.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      opState_q <= OPSTATE_RST;
      modePrev_q <= MODE_STANDBY;
    end else begin
      modePrev_q <= modeIn;
      // RULE12 operating state mirror
      opState_q <= activate ? OPSTATE_RST : modeIn;
    end
  end

  // ****************************************************************
  // Read data multiplexer.
  // ****************************************************************
  // Low bytes always return the shadow, so a random low read gives the
  // bits latched at the last high read of that axis.
  always_comb begin
    rdData = 8'h00;
    unique case (regPtr_q)
      ADDR_STATUS: begin
        rdData[BIT_ALL_OW] = allOverwrite_q;
        rdData[OW_LSB +: AXES] = overwrite_q;
        rdData[BIT_ALL_DR] = allReady_q;
        rdData[DR_LSB +: AXES] = ready_q;
      end
      // RULE7 high byte bits nine to two
      ADDR_X_HI: rdData = sample_q[0][SAMPLE_W-1:2];
      ADDR_Y_HI: rdData = sample_q[1][SAMPLE_W-1:2];
      ADDR_Z_HI: rdData = sample_q[2][SAMPLE_W-1:2];
      // RULE10 low byte follows high byte
      ADDR_X_LO: rdData = {loShadow_q[0], LO_PAD'(0)};
      ADDR_Y_LO: rdData = {loShadow_q[1], LO_PAD'(0)};
      ADDR_Z_LO: rdData = {loShadow_q[2], LO_PAD'(0)};
      ADDR_OPSTATE: rdData = {6'h00, opState_q};
      default: rdData = 8'h00;
    endcase
  end
endmodule

/* bench/asr_sample_regs_checker.sv */
// Port-level checker for the sample and status register group.
module asr_sample_regs_checker
  import asr_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic [asr_pkg::SAMPLE_W-1:0] sampleX,
  input wire logic [asr_pkg::SAMPLE_W-1:0] sampleY,
  input wire logic [asr_pkg::SAMPLE_W-1:0] sampleZ,
  input wire logic sampleValid,
  input wire logic sampleReady,
  input wire logic [asr_pkg::AXES-1:0] axisEnable,
  input wire logic fastRead,
  input wire logic [1:0] modeIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sclP, sdaP, busOpen;
  logic [5:0] lowCnt, openCnt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // ****************************************************************
  // Helper logic.
  // ****************************************************************
  // Pin history, so start and stop are seen on the wire itself.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclP <= 1'b1;
      sdaP <= 1'b1;
    end else begin
      sclP <= sclIn;
      sdaP <= sdaIn;
    end
  end

  // A frame is open from start to stop; the design lags this by its synchroniser.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busOpen <= 1'b0;
    end else if (sclIn && sclP && sdaP && !sdaIn) begin
      busOpen <= 1'b1;
    end else if (sclIn && sclP && !sdaP && sdaIn) begin
      busOpen <= 1'b0;
    end
  end

  // Saturating counts of serial clock low time and of frame age.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lowCnt <= 6'h00;
      openCnt <= 6'h00;
    end else begin
      lowCnt <= sclIn ? 6'h00 : (lowCnt == 6'h3f ? lowCnt : lowCnt + 6'h01);
      openCnt <= !busOpen ? 6'h00 : (openCnt == 6'h3f ? openCnt : openCnt + 6'h01);
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  oe_in_frame_a: assert property (sdaOe |-> busOpen)
    else $error("data pin driven outside a frame");
  oe_timing_a: assert property ($changed(sdaOe) |-> !sclIn && lowCnt >= 6'h02 && lowCnt <= 6'h0c)
    else $error("data pin changed away from the clock fall");
  oe_steady_a: assert property (sclIn && sclP |-> $stable(sdaOe))
    else $error("data pin changed while clock high");
  open_drain_a: assert property (sdaOut == 1'b0)
    else $error("data pin output level not low");
  reset_quiet_a: assert property ($rose(resetn) |-> (!sdaOe) [*3])
    else $error("data pin driven after reset");
  ready_after_reset_a: assert property ($rose(resetn) |-> ##[0:4] sampleReady)
    else $error("sample input not ready after reset");
  full_by_push_a: assert property ($fell(sampleReady) |-> $past(sampleValid))
    else $error("sample input refused without a push");
  pop_when_idle_a: assert property ($rose(sampleReady) |-> !(busOpen && openCnt > 6'h0c))
    else $error("sample taken during an open frame");

  cover property ($rose(sdaOe));
  cover property ($fell(sampleReady));
  cover property (fastRead && sdaOe);
endmodule

bind asr_sample_regs asr_sample_regs_checker chk_i (.clk(clk), .resetn(resetn), .sclIn(sclIn), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .sampleX(sampleX), .sampleY(sampleY), .sampleZ(sampleZ),
  .sampleValid(sampleValid), .sampleReady(sampleReady), .axisEnable(axisEnable), .fastRead(fastRead),
  .modeIn(modeIn));

/* bench/asr_host_model.sv */
// Serial bus master model standing in for the host processor.
module asr_host_model (
  input wire logic clk,
  input wire logic sdaOe,
  output logic sclLine,
  output logic sdaLine
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sclQ = 1'b1;
  logic sdaQ = 1'b1;

  // Pulled-up wire: whichever party pulls low wins.
  assign sdaLine = sdaQ & ~sdaOe;
  assign sclLine = sclQ;

  // Every change lands just after a clock edge.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Start or repeated start; the clock stands high between frames.
  task automatic start();
    sdaQ = 1'b1;
    tick(10);
    sclQ = 1'b1;
    tick(10);
    sdaQ = 1'b0;
    tick(10);
    sclQ = 1'b0;
  endtask

  task automatic stop();
    tick(5);
    sdaQ = 1'b0;
    tick(10);
    sclQ = 1'b1;
    tick(10);
    sdaQ = 1'b1;
    tick(10);
  endtask

  // One bit of 160 ns; data moves well clear of both clock edges.
  task automatic bitx(input logic b, output logic r);
    tick(5);
    sdaQ = b;
    tick(15);
    sclQ = 1'b1;
    tick(10);
    r = sdaLine;
    tick(10);
    sclQ = 1'b0;
  endtask

  // bursts only, no lone low read.
  task automatic xbyte(input logic [7:0] w, input logic ackIn, output logic [7:0] r, output logic ackOut);
    for (int i = 7; i >= 0; i--) bitx(w[i], r[i]);
    bitx(ackIn, ackOut);
  endtask
endmodule

/* bench/asr_sample_regs_tb_top.sv */
// Self-checking bench for the sample and status register group.
module asr_sample_regs_tb_top;
  import asr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LIMIT = 80000;
  logic clk = 1'b0;
  logic resetn;
  logic sclIn, sdaIn, sdaOut, sdaOe, sampleReady, fastRead, sampleValid;
  logic [SAMPLE_W-1:0] sampleX, sampleY, sampleZ;
  logic [AXES-1:0] axisEnable;
  logic [1:0] modeIn;
  logic [7:0] rb [0:7];
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  int seed = 32'hee57;

  always #2 clk = ~clk;

  asr_host_model host (.clk(clk), .sdaOe(sdaOe), .sclLine(sclIn), .sdaLine(sdaIn));
  asr_sample_regs uut (.clk(clk), .resetn(resetn), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .sampleX(sampleX), .sampleY(sampleY), .sampleZ(sampleZ), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .axisEnable(axisEnable), .fastRead(fastRead), .modeIn(modeIn));

  // ****************************************************************
  // Expectations and checks.
  // ****************************************************************
  function automatic logic [7:0] stat(input logic [2:0] ow, input logic [2:0] dr);
    return {|ow, ow, |dr, dr};
  endfunction

  // Byte k of a burst from the first high byte: high bytes even, low bytes odd.
  function automatic logic [7:0] byteOf(input logic [29:0] s, input int k);
    logic [SAMPLE_W-1:0] v;
    v = s[(k / 2) * SAMPLE_W +: SAMPLE_W];
    return (k % 2 == 0) ? v[9:2] : {v[1:0], 6'h00};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("mismatches %0d, checks %0d", n_mismatch, n_checks);
    if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // A hang is cut short and counted against the run.
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      close_out();
    end
  end

  // ****************************************************************
  // Transfers.
  // ****************************************************************
  task automatic push(input logic [29:0] s);
    // One edge passes first, so back-to-back pushes never touch the strobe twice at once.
    host.tick(1);
    {sampleZ, sampleY, sampleX} = s;
    sampleValid = 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(posedge clk);
      if (sampleReady === 1'b1) break;
    end
    #1 sampleValid = 1'b0;
  endtask

  // A pointer of ff keeps the stored one; a sample may be pushed after the first high byte.
  task automatic rd(input logic [7:0] ptr, input int n, input logic [29:0] mid, input logic midOn);
    logic [7:0] r;
    logic a;
    host.start();
    if (ptr !== 8'hff) begin
      host.xbyte({DEV_ADDR, 1'b0}, 1'b1, r, a);
      host.xbyte(ptr, 1'b1, r, a);
      host.start();
    end
    host.xbyte({DEV_ADDR, 1'b1}, 1'b1, r, a);
    for (int i = 0; i < n; i++) begin
      host.xbyte(8'hff, i == n - 1, rb[i], a);
      if (midOn && i == 1) push(mid);
    end
    host.stop();
    host.tick(20);
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    logic [7:0] r;
    logic a;
    host.start();
    host.xbyte({DEV_ADDR, 1'b0}, 1'b1, r, a);
    host.xbyte(ptr, 1'b1, r, a);
    host.xbyte(d, 1'b1, r, a);
    host.stop();
    host.tick(20);
  endtask

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    logic [29:0] a, b, e;
    logic [7:0] r;
    logic k1;
    int got;
    // Every input of the design starts from a known level at time zero.
    resetn = 1'b0;
    fastRead = 1'b0;
    sampleValid = 1'b0;
    {sampleZ, sampleY, sampleX} = 30'($random(seed));
    axisEnable = 3'h7;
    modeIn = MODE_STANDBY;
    repeat (4) @(posedge clk);
    #1 resetn = 1'b1;
    host.tick(4);
    rd(ADDR_OPSTATE, 1, '0, 1'b0);
    chk(rb[0], {6'h00, MODE_STANDBY});
    push(30'h3fffffff);
    host.tick(10);
    modeIn = MODE_WAKE;
    host.tick(5);
    rd(ADDR_STATUS, 2, '0, 1'b0);
    chk(rb[0], STATUS_RST);
    chk(rb[1], 8'h00);
    for (int m = 1; m < 3; m++) begin
      modeIn = 2'(m);
      host.tick(3);
      rd(ADDR_OPSTATE, 1, '0, 1'b0);
      chk(rb[0], 8'(m));
    end
    a = {10'h001, 10'h1ff, 10'h200};
    b = 30'($random(seed));
    push(a);
    host.tick(10);
    rd(ADDR_STATUS, 7, b, 1'b1);
    chk(rb[0], stat(3'h0, 3'h7));
    for (int k = 0; k < 6; k++) chk(rb[k + 1], byteOf(a, k));
    rd(ADDR_STATUS, 7, '0, 1'b0);
    chk(rb[0], stat(3'h0, 3'h7));
    for (int k = 0; k < 6; k++) chk(rb[k + 1], byteOf(b, k));
    a = 30'($random(seed));
    b = 30'($random(seed));
    push(a);
    push(b);
    host.tick(10);
    fastRead = 1'b1;
    rd(ADDR_STATUS, 5, '0, 1'b0);
    chk(rb[0], stat(3'h7, 3'h7));
    for (int k = 0; k < 3; k++) chk(rb[k + 1], byteOf(b, 2 * k));
    chk(rb[4], stat(3'h0, 3'h0));
    fastRead = 1'b0;
    e = 30'($random(seed));
    axisEnable = 3'h1;
    push(e);
    host.tick(10);
    rd(ADDR_STATUS, 4, '0, 1'b0);
    chk(rb[0], stat(3'h0, 3'h1));
    chk(rb[1], byteOf(e, 0));
    chk(rb[3], byteOf(b, 2));
    axisEnable = 3'h7;
    wr(ADDR_STATUS, 8'hff);
    wr(ADDR_X_HI, 8'hff);
    rd(ADDR_STATUS, 2, '0, 1'b0);
    chk(rb[0], 8'h00);
    chk(rb[1], byteOf(e, 0));
    wr(ADDR_Z_HI, 8'h00);
    rd(8'hff, 1, '0, 1'b0);
    chk(rb[0], 8'h00);
    // Fill the queue while a frame holds samples off, then drain it.
    host.start();
    host.xbyte({DEV_ADDR, 1'b0}, 1'b1, r, k1);
    got = 0;
    sampleValid = 1'b1;
    for (int k = 0; k < 24; k++) begin
      e = 30'($random(seed));
      {sampleZ, sampleY, sampleX} = e;
      @(posedge clk);
      if (sampleReady === 1'b1) begin
        got++;
        b = e;
      end
      #1;
    end
    sampleValid = 1'b0;
    chk(8'(got), 8'(FIFO_DEPTH));
    host.stop();
    host.tick(100);
    rd(ADDR_STATUS, 7, '0, 1'b0);
    chk(rb[0], stat(3'h7, 3'h7));
    for (int k = 0; k < 6; k++) chk(rb[k + 1], byteOf(b, k));
    close_out();
  end
endmodule
